// ==== gcx_bank_chk.sv ====
// Checker of pin drive and coexistence role mapping.
`timescale 1ns/1ps
module gcx_bank_chk (
    input wire clk_sys,
    input wire rstn,
    input wire [4:0] pin_dir_out,
    input wire [4:0] pin_out_val,
    input wire host_wake_en,
    input wire host_wake_out,
    input wire [1:0] coex_mode,
    input wire coex_serial_out,
    input wire coex_priority,
    input wire [4:0] pin_o,
    input wire [4:0] pin_oe,
    input wire peer_frame_sync
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_w4;
        coex_mode == 2'h3;
    endsequence
    AST_RST: assert property (disable iff (1'b0) $rose(rstn) |-> !pin_oe)
        else $error("pins driven after reset");
    AST_W2: assert property (coex_mode == 2'h1 |=> pin_oe[2:1] == 2'h1
        && pin_o[1] == $past(coex_serial_out)) else $error("two-wire map");
    AST_W3: assert property (coex_mode == 2'h2 |=> pin_oe[4:2] == 3'h1
        && pin_o[2] == $past(coex_priority)) else $error("three-wire map");
    AST_W4: assert property (s_w4 |=> pin_oe[4:1] == 4'h1
        && pin_o[1] == $past(coex_priority)) else $error("four-wire map");
    AST_FS: assert property (coex_mode != 2'h3 |=> !peer_frame_sync)
        else $error("frame sync outside four-wire");
    AST_WAKE: assert property (host_wake_en |=> pin_oe[0]
        && pin_o[0] == $past(host_wake_out)) else $error("wake pin");
    AST_OFF: assert property (coex_mode == 2'h0 |=> pin_oe[4:1]
        == $past(pin_dir_out[4:1])) else $error("plain direction");
    AST_P0: assert property (!host_wake_en |=> pin_oe[0]
        == $past(pin_dir_out[0])) else $error("pin 0 direction");
    AST_VAL: assert property (coex_mode == 2'h0 |=> (pin_o[4:1] & pin_oe[4:1])
        == ($past(pin_out_val[4:1]) & pin_oe[4:1])) else $error("plain pin levels");
    AST_V0: assert property (!host_wake_en && pin_dir_out[0] |=> pin_o[0]
        == $past(pin_out_val[0])) else $error("pin 0 level");
endmodule
bind gcx_pin_bank gcx_bank_chk u_chk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_dir_out(pin_dir_out),
    .pin_out_val(pin_out_val),
    .host_wake_en(host_wake_en),
    .host_wake_out(host_wake_out),
    .coex_mode(coex_mode),
    .coex_serial_out(coex_serial_out),
    .coex_priority(coex_priority),
    .pin_o(pin_o),
    .pin_oe(pin_oe),
    .peer_frame_sync(peer_frame_sync)
);

// ==== gcx_consts.vh ====
// Constants for the general-purpose pin bank with coexistence pin functions.
`ifndef GCX_CONSTS_VH
`define GCX_CONSTS_VH
`define GCX_NUM_PINS 5
`define GCX_PULL_NONE 2'h0
`define GCX_PULL_UP 2'h1
`define GCX_PULL_DOWN 2'h2
`define GCX_COEX_OFF 2'h0
`define GCX_COEX_2W 2'h1
`define GCX_COEX_3W 2'h2
`define GCX_COEX_4W 2'h3
`define GCX_PIN_WAKE 0
`define GCX_PIN_1 1
`define GCX_PIN_2 2
`define GCX_PIN_3 3
`define GCX_PIN_4 4
`define GCX_DIR_RST 5'h00
`define GCX_PULL_RST 10'h000
`endif

// ==== gcx_peer.sv ====
// Peer chip model that resolves the level of every pin.
`timescale 1ns/1ps
module gcx_peer (
    input wire clk_sys,
    input wire [4:0] pin_o,
    input wire [4:0] pin_oe,
    input wire [4:0] pin_pull_up,
    input wire [4:0] pin_pull_dn,
    input wire [4:0] de,
    input wire [4:0] dv,
    output wire [4:0] pin_i
);
    logic tog = 1'b0;
    always @(posedge clk_sys) tog <= !tog;
    // Peer drives only released pins; a floating pin toggles every cycle.
    assign pin_i = pin_oe & pin_o | ~pin_oe & (de & dv | ~de & (pin_pull_up
        | ~pin_pull_dn & {5{tog}}));
endmodule

// ==== gcx_pin_bank.v ====
// Five-pin general-purpose bank with selectable coexistence pin roles.
`timescale 1ns/1ps
`include "gcx_consts.vh"
module gcx_pin_bank (
    clk_sys,
    rstn,
    pin_dir_out,
    pin_out_val,
    pin_pull_sel,
    host_wake_en,
    host_wake_out,
    coex_mode,
    coex_serial_out,
    coex_priority,
    pin_i,
    pin_o,
    pin_oe,
    pin_pull_up,
    pin_pull_dn,
    pin_in_val,
    coex_serial_in,
    peer_receive_active,
    peer_transmit_active,
    peer_frame_sync,
    coex_mode_active
);
    input wire clk_sys;
    input wire rstn;
    input wire [4:0] pin_dir_out;
    input wire [4:0] pin_out_val;
    input wire [9:0] pin_pull_sel;
    input wire host_wake_en;
    input wire host_wake_out;
    input wire [1:0] coex_mode;
    input wire coex_serial_out;
    input wire coex_priority;
    input wire [4:0] pin_i;
    output wire [4:0] pin_o;
    output wire [4:0] pin_oe;
    output wire [4:0] pin_pull_up;
    output wire [4:0] pin_pull_dn;
    output wire [4:0] pin_in_val;
    output reg coex_serial_in;
    output reg peer_receive_active;
    output reg peer_transmit_active;
    output reg peer_frame_sync;
    output reg [1:0] coex_mode_active;

    reg [4:0] drv_en;
    reg [4:0] drv_val;
    reg [4:0] claim_out;
    reg [4:0] claim_in;
    reg [4:0] role_val;
    reg [3:0] role_in_nxt;
    genvar g;

    // Bit positions of the peer roles inside role_in_nxt.
    localparam ROLE_SERIAL = 3;
    localparam ROLE_SYNC = 2;
    localparam ROLE_RX = 1;
    localparam ROLE_TX = 0;

    // Pins that the coexistence mode drives as outputs.
    function [4:0] mode_out_mask;
        input [1:0] mode;
        begin
            case (mode)
                `GCX_COEX_2W: begin
                    mode_out_mask = 5'h01 << `GCX_PIN_1;
                end
                `GCX_COEX_3W: begin
                    mode_out_mask = 5'h01 << `GCX_PIN_2;
                end
                `GCX_COEX_4W: begin
                    mode_out_mask = 5'h01 << `GCX_PIN_1;
                end
                default: begin
                    mode_out_mask = 5'h00;
                end
            endcase
        end
    endfunction

    // Pins that the coexistence mode holds as inputs from the peer.
    function [4:0] mode_in_mask;
        input [1:0] mode;
        begin
            case (mode)
                `GCX_COEX_2W: begin
                    mode_in_mask = 5'h01 << `GCX_PIN_2;
                end
                `GCX_COEX_3W: begin
                    mode_in_mask = (5'h01 << `GCX_PIN_3) | (5'h01 << `GCX_PIN_4);
                end
                `GCX_COEX_4W: begin
                    mode_in_mask = (5'h01 << `GCX_PIN_2) | (5'h01 << `GCX_PIN_3) |
                        (5'h01 << `GCX_PIN_4);
                end
                default: begin
                    mode_in_mask = 5'h00;
                end
            endcase
        end
    endfunction

    // Levels that the coexistence mode puts on the pins it drives.
    function [4:0] mode_out_val;
        input [1:0] mode;
        input serial;
        input prio;
        begin
            mode_out_val = 5'h00;
            case (mode)
                `GCX_COEX_2W: begin
                    mode_out_val[`GCX_PIN_1] = serial;
                end
                `GCX_COEX_3W: begin
                    mode_out_val[`GCX_PIN_2] = prio;
                end
                `GCX_COEX_4W: begin
                    mode_out_val[`GCX_PIN_1] = prio;
                end
                default: begin
                    mode_out_val = 5'h00;
                end
            endcase
        end
    endfunction

    // Peer roles seen on the pins, zero unless the mode gives the pin that role.
    function [3:0] mode_role_in;
        input [1:0] mode;
        input [4:0] lvl;
        begin
            mode_role_in = 4'h0;
            case (mode)
                `GCX_COEX_2W: begin
                    mode_role_in[ROLE_SERIAL] = lvl[`GCX_PIN_2];
                end
                `GCX_COEX_3W: begin
                    mode_role_in[ROLE_RX] = lvl[`GCX_PIN_3];
                    mode_role_in[ROLE_TX] = lvl[`GCX_PIN_4];
                end
                `GCX_COEX_4W: begin
                    mode_role_in[ROLE_SYNC] = lvl[`GCX_PIN_2];
                    mode_role_in[ROLE_RX] = lvl[`GCX_PIN_3];
                    mode_role_in[ROLE_TX] = lvl[`GCX_PIN_4];
                end
                default: begin
                    mode_role_in = 4'h0;
                end
            endcase
        end
    endfunction

    // Pin directions: mode inputs released, mode outputs and the wake pin driven.
    always @* begin
        claim_out = mode_out_mask(coex_mode);
        claim_in = mode_in_mask(coex_mode);
        drv_en = pin_dir_out;
        drv_en = drv_en & ~claim_in;
        drv_en = drv_en | claim_out;
        if (host_wake_en) begin
            drv_en[`GCX_PIN_WAKE] = 1'b1;
        end
    end

    // Pin levels: plain values, overridden by mode roles and the wake level.
    always @* begin
        role_val = mode_out_val(coex_mode, coex_serial_out, coex_priority);
        drv_val = pin_out_val;
        drv_val = drv_val & ~claim_out;
        drv_val = drv_val | (role_val & claim_out);
        if (host_wake_en) begin
            drv_val[`GCX_PIN_WAKE] = host_wake_out;
        end
    end

    // Peer role inputs, zero outside the mode that owns them.
    always @* begin
        role_in_nxt = mode_role_in(coex_mode, pin_i);
    end

    generate
        for (g = 0; g < `GCX_NUM_PINS; g = g + 1) begin : cells
            gcx_pin_cell u_cell (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .drive_en(drv_en[g]),
                .drive_val(drv_val[g]),
                .pull_sel(pin_pull_sel[2*g+1:2*g]),
                .pin_i(pin_i[g]),
                .pin_o(pin_o[g]),
                .pin_oe(pin_oe[g]),
                .pull_up_en(pin_pull_up[g]),
                .pull_dn_en(pin_pull_dn[g]),
                .in_val(pin_in_val[g])
            );
        end
    endgenerate

    // Coexistence inputs from the peer, gated by the active mode.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            coex_serial_in <= 1'b0;
            peer_receive_active <= 1'b0;
            peer_transmit_active <= 1'b0;
            peer_frame_sync <= 1'b0;
            coex_mode_active <= `GCX_COEX_OFF;
        end else begin
            coex_mode_active <= coex_mode;
            coex_serial_in <= role_in_nxt[ROLE_SERIAL];
            peer_frame_sync <= role_in_nxt[ROLE_SYNC];
            peer_receive_active <= role_in_nxt[ROLE_RX];
            peer_transmit_active <= role_in_nxt[ROLE_TX];
        end
    end
endmodule

// ==== gcx_pin_cell.v ====
// One pin cell: drive enable, pull selection and input capture.
`timescale 1ns/1ps
`include "gcx_consts.vh"
module gcx_pin_cell (
    clk_sys,
    rstn,
    drive_en,
    drive_val,
    pull_sel,
    pin_i,
    pin_o,
    pin_oe,
    pull_up_en,
    pull_dn_en,
    in_val
);
    input wire clk_sys;
    input wire rstn;
    input wire drive_en;
    input wire drive_val;
    input wire [1:0] pull_sel;
    input wire pin_i;
    output reg pin_o;
    output reg pin_oe;
    output reg pull_up_en;
    output reg pull_dn_en;
    output reg in_val;

    // Registered so every output comes from a flip-flop; reset leaves the pin floating.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
            pull_up_en <= 1'b0;
            pull_dn_en <= 1'b0;
            in_val <= 1'b0;
        end else begin
            pin_o <= drive_val;
            pin_oe <= drive_en;
            pull_up_en <= (pull_sel == `GCX_PULL_UP);
            pull_dn_en <= (pull_sel == `GCX_PULL_DOWN);
            in_val <= pin_i;
        end
    end
endmodule

// ==== testbench.sv ====
// Random and corner stimulus bench for the pin bank.
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0, rstn = 1'b0, host_wake_en, host_wake_out, coex_serial_out;
    logic coex_priority;
    logic [1:0] coex_mode;
    logic [4:0] pin_dir_out, pin_out_val, de, dv, pi;
    logic [9:0] pin_pull_sel;
    logic [4:0] eo, ev;
    wire [4:0] pin_i, pin_o, pin_oe, pin_pull_up, pin_pull_dn, pin_in_val;
    wire coex_serial_in, peer_receive_active, peer_transmit_active, peer_frame_sync;
    wire [1:0] coex_mode_active;
    wire [3:0] got = {coex_serial_in, peer_frame_sync, peer_receive_active, peer_transmit_active};
    wire [3:0] want = {coex_mode == 2'h1 && pi[2], coex_mode == 2'h3 && pi[2],
        coex_mode[1] && pi[3], coex_mode[1] && pi[4]};
    wire [3:0] roles = {host_wake_en, host_wake_out, coex_serial_out, coex_priority};
    int num_errors = 0, comparisons = 0;
    always #25 clk_sys = !clk_sys;
    gcx_pin_bank uut (.*);
    gcx_peer peer (.*);
    function automatic [4:0] pulls(input [9:0] p, input [1:0] c);
        for (int g = 0; g < 5; g++) pulls[g] = p[2*g+:2] == c;
    endfunction
    function automatic [4:0] exp_oe(input [1:0] m, input [4:0] dir, input w);
        exp_oe = dir;
        if (w) exp_oe[0] = 1'b1;
        if (m == 2'h1) exp_oe[2:1] = 2'h1;
        if (m == 2'h2) exp_oe[4:2] = 3'h1;
        if (m == 2'h3) exp_oe[4:1] = 4'h1;
    endfunction
    function automatic [4:0] exp_o(input [1:0] m, input [4:0] v, input [3:0] r);
        exp_o = v;
        if (r[3]) exp_o[0] = r[2];
        if (m == 2'h1) exp_o[1] = r[1];
        if (m == 2'h2) exp_o[2] = r[0];
        if (m == 2'h3) exp_o[1] = r[0];
    endfunction
    task chk(input [4:0] s, input [4:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task rnd;
        {pin_dir_out, pin_out_val, de, dv, pin_pull_sel} = 30'($urandom);
        {host_wake_en, host_wake_out, coex_serial_out, coex_priority, coex_mode} = 6'($urandom);
    endtask
    initial begin
        void'($urandom(32'h5A7A38CC));
        rnd();
        repeat (20) @(negedge clk_sys);
        for (int i = 0; i < 400; i++) begin
            rstn = i < 200 || i > 201;
            rnd();
            if (i < 4) coex_mode = i[1:0];
            #1 pi = pin_i;
            @(negedge clk_sys);
            if (rstn) begin
                chk(pin_pull_up, pulls(pin_pull_sel, 2'h1));
                chk(pin_pull_dn, pulls(pin_pull_sel, 2'h2));
                chk(pin_in_val, pi);
                chk({3'h0, coex_mode_active}, {3'h0, coex_mode});
                chk({1'h0, got}, {1'h0, want});
                eo = exp_oe(coex_mode, pin_dir_out, host_wake_en);
                ev = exp_o(coex_mode, pin_out_val, roles);
                chk(pin_oe, eo);
                chk(pin_o & eo, ev & eo);
            end else chk(pin_oe | pin_pull_up | pin_pull_dn | pin_o | pin_in_val, 5'h00);
        end
        wrap_up();
    end
endmodule
